// ==== hdl/keypad_pin_interrupt.v ====
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "keypad_pin_interrupt_defs.vh"
module keypad_pin_interrupt #(
  parameter PINS = 8
)(
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [PINS-1:0] interrupt_input_pin,
  output reg [PINS-1:0] pull_up_enable,
  output reg [PINS-1:0] pull_down_enable,
  output reg irq
);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  reg event_flag;
  reg irq_request_enable;
  reg detect_mode_select;
  reg [PINS-1:0] pin_source_enable;
  reg [PINS-1:0] pin_polarity_select;
  reg [PINS-1:0] port_pull_enable;

  // ****************************************************************
  // Pin synchroniser and detection.
  // ****************************************************************
  reg [PINS-1:0] pin_meta;
  reg [PINS-1:0] pin_sync;
  reg [PINS-1:0] pin_prev;
  reg edge_armed;

  // A pin is asserted when its level matches its polarity and it is enabled.
  function [PINS-1:0] asserted_mask;
    input [PINS-1:0] level;
    input [PINS-1:0] polarity;
    input [PINS-1:0] enable;
    begin
      asserted_mask = ~(level ^ polarity) & enable;
    end
  endfunction

  wire [PINS-1:0] asserted_now = asserted_mask(pin_sync, pin_polarity_select, pin_source_enable);
  wire [PINS-1:0] asserted_prev = asserted_mask(pin_prev, pin_polarity_select, pin_source_enable);
  wire any_asserted = |asserted_now;
  wire edge_seen = edge_armed & (|(asserted_now & ~asserted_prev));
  wire detect_event = edge_seen | (detect_mode_select & any_asserted);

  // ****************************************************************
  // Bus write path.
  // ****************************************************************
  reg [3:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_addr_ok = aw_held | (s_axi_awvalid & s_axi_awready);
  wire wr_data_ok = w_held | (s_axi_wvalid & s_axi_wready);
  wire wr_fire = wr_addr_ok & wr_data_ok & ~s_axi_bvalid;
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire ack_write = wr_lane0 & (wr_addr == `ADDR_STATUS_CONTROL) & wr_data[`BIT_ACK];

  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `ADDR_STATUS_CONTROL) | (addr == `ADDR_PIN_ENABLE) |
               (addr == `ADDR_POLARITY) | (addr == `ADDR_PULL_ENABLE);
    end
  endfunction

  function [7:0] read_byte;
    input [3:0] addr;
    begin
      case (addr)
        `ADDR_STATUS_CONTROL:
          read_byte = {4'h0, event_flag, 1'b0, irq_request_enable, detect_mode_select};
        `ADDR_PIN_ENABLE: read_byte = pin_source_enable;
        `ADDR_POLARITY: read_byte = pin_polarity_select;
        `ADDR_PULL_ENABLE: read_byte = port_pull_enable;
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchroniser and previous sample.
  // ****************************************************************
  // The pins are not timed to aclk, so two flops stand before any logic reads them.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= {PINS{1'b0}};
      pin_sync <= {PINS{1'b0}};
    end
    else
    begin
      pin_meta <= interrupt_input_pin;
      pin_sync <= pin_meta;
    end
  end

  // Only the second flop feeds this one, never the first.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_prev <= {PINS{1'b0}};
    end
    else
    begin
      pin_prev <= pin_sync;
    end
  end

  // ****************************************************************
  // Edge arming.
  // ****************************************************************
  // Rearm only once every enabled input has gone back to rest, so a held key
  // cannot let a second key pressed beside it make a fresh edge.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edge_armed <= 1'b1;
    end
    else if (edge_seen)
    begin
      edge_armed <= 1'b0;
    end
    else if (!any_asserted)
    begin
      edge_armed <= 1'b1;
    end
  end

  // ****************************************************************
  // Event flag.
  // ****************************************************************
  wire ack_clears = ack_write & (~detect_mode_select | ~any_asserted);
  // Set wins over acknowledge so an event in that cycle is not lost.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_flag <= 1'b0;
    end
    else if (detect_event)
    begin
      event_flag <= 1'b1;
    end
    else if (ack_clears)
    begin
      event_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt request.
  // ****************************************************************
  // Registered so the request line never glitches; it lags the flag by one cycle.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= event_flag & irq_request_enable;
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  // Only byte lane 0 carries data; a write with that lane off changes nothing.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_request_enable <= 1'b0;
      detect_mode_select <= 1'b0;
      pin_source_enable <= `RESET_BYTE;
      pin_polarity_select <= `RESET_BYTE;
      port_pull_enable <= `RESET_BYTE;
    end
    else if (wr_lane0)
    begin
      case (wr_addr)
        `ADDR_STATUS_CONTROL:
        begin
          irq_request_enable <= wr_data[`BIT_IRQ_ENABLE];
          detect_mode_select <= wr_data[`BIT_MODE];
        end
        `ADDR_PIN_ENABLE: pin_source_enable <= wr_data[PINS-1:0];
        `ADDR_POLARITY: pin_polarity_select <= wr_data[PINS-1:0];
        `ADDR_PULL_ENABLE: port_pull_enable <= wr_data[PINS-1:0];
        default: port_pull_enable <= port_pull_enable;
      endcase
    end
  end

  // ****************************************************************
  // Pull resistor controls.
  // ****************************************************************
  // A pull toward the rest level keeps an open key from floating into an event.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pull_up_enable <= {PINS{1'b0}};
      pull_down_enable <= {PINS{1'b0}};
    end
    else
    begin
      pull_up_enable <= port_pull_enable & ~pin_polarity_select;
      pull_down_enable <= port_pull_enable & pin_polarity_select;
    end
  end

  // ****************************************************************
  // Write address channel.
  // ****************************************************************
  // Ready is a one-cycle pulse; the address is parked until its data comes.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end
    else if (wr_fire)
    begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
    end
  end

  // ****************************************************************
  // Write data channel.
  // ****************************************************************
  // Data may come before the address; it is parked the same way.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (wr_fire)
    begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // ****************************************************************
  // Write response channel.
  // ****************************************************************
  // The response follows the edge on which both halves of the write are in hand.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Read channels.
  // ****************************************************************
  // Reads take one cycle after the address is taken.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
    end
  end

  // Read data stands until rready is seen.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, read_byte(s_axi_araddr)};
      s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // keypad_pin_interrupt

// ==== hdl/keypad_pin_interrupt_defs.vh ====
`ifndef KEYPAD_PIN_INTERRUPT_DEFS_VH
`define KEYPAD_PIN_INTERRUPT_DEFS_VH
// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define ADDR_STATUS_CONTROL 4'h0
`define ADDR_PIN_ENABLE 4'h4
`define ADDR_POLARITY 4'h8
`define ADDR_PULL_ENABLE 4'hC
// ****************************************************************
// Status and control field positions.
// ****************************************************************
`define BIT_EVENT_FLAG 3
`define BIT_ACK 2
`define BIT_IRQ_ENABLE 1
`define BIT_MODE 0
// ****************************************************************
// Reset values and bus answers.
// ****************************************************************
`define RESET_BYTE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== test/key_switches.sv ====
`timescale 1ns/1ns
module key_switches (
  input wire logic aclk,
  input wire logic [7:0] press, up, dn,
  output logic [7:0] pin
);
  logic [7:0] fl = 8'h00;
  // An open input with no pull wanders, so a stale level is never trusted.
  always @(posedge aclk) fl <= ~fl;
  assign pin = (press & dn) | (~press & up) | (~up & ~dn & fl);
endmodule // key_switches

// ==== test/keypad_pin_interrupt_props.sv ====
`timescale 1ns/1ns
module keypad_pin_interrupt_props #(parameter PINS = 8) (
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, irq,
  input wire logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [PINS-1:0] interrupt_input_pin, pull_up_enable, pull_down_enable
);
  logic [PINS-1:0] rg [0:3];
  logic [3:0] ra;
  // Shadow copies assume address and data are taken together, as the bench offers them.
  wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  wire [PINS-1:0] asr = rg[1] & ~(rg[2] ^ interrupt_input_pin);
  wire ie = rg[0][1];
  always @(posedge aclk)
  begin
    if (!aresetn)
      rg <= '{default: '0};
    else if (wr)
      rg[s_axi_awaddr[3:2]] <= s_axi_wdata[PINS-1:0];
    if (s_axi_arvalid && s_axi_arready)
      ra <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rd_zero;
    s_axi_rvalid && ra == 4'h0 |-> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[2];
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("status read bad");
  property p_mask; !ie && !$past(ie) |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_rise; $rose(irq) |-> $past(ie); endproperty
  a_rise: assert property (p_rise) else $error("irq rose masked");
  property p_edge; ie && $past(asr) == '0 && asr != '0 |-> ##[1:6] irq; endproperty
  a_edge: assert property (p_edge) else $error("edge missed");
  property p_hold;
    wr && s_axi_awaddr == 4'h0 && s_axi_wdata[2:0] == 3'h7 && irq
      && (asr & $past(asr) & $past(asr, 2) & $past(asr, 3)) != '0 |=> irq [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_pulls;
    $stable(rg[3]) && $stable(rg[2]) |->
      pull_up_enable == (rg[3] & ~rg[2]) && pull_down_enable == (rg[3] & rg[2]);
  endproperty
  a_pulls: assert property (p_pulls) else $error("pull mismatch");
  property p_bresp; wr |-> ##1 s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("late write answer");
  property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("late read answer");
endmodule // keypad_pin_interrupt_props
bind keypad_pin_interrupt keypad_pin_interrupt_props #(.PINS(PINS)) i_props (.*);

// ==== test/tb.sv ====
`timescale 1ns/1ns
`include "keypad_pin_interrupt_defs.vh"
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
  logic [7:0] press = 8'h00, interrupt_input_pin, pull_up_enable, pull_down_enable;
  int miscompares = 0, samples_checked = 0;
  keypad_pin_interrupt i_keypad_pin_interrupt (.*);
  key_switches i_key_switches (.aclk(aclk), .press(press), .up(pull_up_enable),
    .dn(pull_down_enable), .pin(interrupt_input_pin));
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    bs = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    q = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 16; a += 4)
    begin
      rd(a[3:0]);
      chk("reset", q, 32'h0);
    end
    rd(4'h2);
    chk("unmapped", {30'h0, rs}, {30'h0, `RESP_SLVERR});
    wr(4'h2, 8'h55);
    chk("wr_unmapped", {30'h0, bs}, {30'h0, `RESP_SLVERR});
    wr(`ADDR_STATUS_CONTROL, 8'h00);
    chk("wr_okay", {30'h0, bs}, {30'h0, `RESP_OKAY});
    wr(`ADDR_POLARITY, 8'h0F);
    wr(`ADDR_PULL_ENABLE, 8'hFF);
    repeat (2) @(posedge aclk);
    chk("pull_up", {24'h0, pull_up_enable}, 32'hF0);
    chk("pull_down", {24'h0, pull_down_enable}, 32'h0F);
    wr(`ADDR_PIN_ENABLE, 8'hFF);
    wr(`ADDR_STATUS_CONTROL, 8'h04);
    wr(`ADDR_STATUS_CONTROL, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      press <= 8'h01 << i;
      repeat (6) @(posedge aclk);
      chk("irq_edge", {31'h0, irq}, 32'h1);
      rd(`ADDR_STATUS_CONTROL);
      chk("flag_set", q, 32'h0A);
      press <= 8'h00;
      wr(`ADDR_STATUS_CONTROL, 8'h06);
      repeat (3) @(posedge aclk);
      chk("irq_ack", {31'h0, irq}, 32'h0);
    end
    press <= 8'h02;
    repeat (6) @(posedge aclk);
    wr(`ADDR_STATUS_CONTROL, 8'h06);
    press <= 8'h06;
    repeat (6) @(posedge aclk);
    chk("no_rearm", {31'h0, irq}, 32'h0);
    wr(`ADDR_STATUS_CONTROL, 8'h03);
    wr(`ADDR_STATUS_CONTROL, 8'h07);
    rd(`ADDR_STATUS_CONTROL);
    chk("flag_held", q, 32'h0B);
    press <= 8'h00;
    wr(`ADDR_STATUS_CONTROL, 8'h01);
    rd(`ADDR_STATUS_CONTROL);
    chk("flag_masked", q, 32'h09);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(`ADDR_STATUS_CONTROL, 8'h05);
    wr(`ADDR_STATUS_CONTROL, 8'hFF);
    rd(`ADDR_STATUS_CONTROL);
    chk("status_bits", q, 32'h03);
    wr(`ADDR_PIN_ENABLE, 8'hFE);
    press <= 8'h01;
    repeat (6) @(posedge aclk);
    chk("pin_off", {31'h0, irq}, 32'h0);
    end_sim();
  end
endmodule // tb
